// >>> hdl/parallel_io_ports.v
// Functional notes
// - each pin of all seven ports is separately set as input or output.
// - ports A, C, D, F have per-bit pullups, active only on inputs.
// - an output bit has its pullup forced off; it returns on input.
// - direction registers A to E sit at fixed offsets, reset to zero.
// - unused upper bits of C and E registers read zero, ignore writes.
// - pullup enables A, C, D at consecutive offsets, reset to zero.
// - pins hand over to keyboard, converter and CAN under their enables.
// - direction one enables the output driver, zero disables it.
// - data read gives latch for outputs, sampled pin for inputs.
// - latch writes always land; on inputs they do not reach the pin.
`timescale 1ns/1ns
`include "parallel_io_ports_defs.vh"

module parallel_io_ports (
	input wire clk,
	input wire srst,
	input wire [12:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output reg waitrequest,
	input wire [55:0] pinIn,
	output reg [55:0] pinOut,
	output reg [55:0] pinOe,
	output reg [55:0] pullupOn,
	input wire [7:0] keyboardPinEnable,
	input wire [4:0] converterChannelSelect,
	input wire converterActive,
	input wire canPinEnable,
	input wire canTxData
);

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------

	// one-hot of the port pin that the converter channel selects
	// channels beyond the three converter ports hit no pin at all
	function [7:0] channelHit;
		input [4:0] sel;
		input [4:0] base;
		input active;
		reg [4:0] diff;
		begin
			diff = sel - base;
			channelHit = 8'h00;
			if (active && (sel >= base) && (diff < 5'h08)) begin
				channelHit = 8'h01 << diff[2:0];
			end
		end
	endfunction

	// data read: latch where the direction bit is one, pin level where it is zero
	function [7:0] portRead;
		input [7:0] latch;
		input [7:0] dir;
		input [7:0] pin;
		input [7:0] mask;
		begin
			portRead = ((latch & dir) | (pin & ~dir)) & mask;
		end
	endfunction

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	reg [7:0] dirA;
	reg [7:0] dirB;
	reg [7:0] dirC;
	reg [7:0] dirD;
	reg [7:0] dirE;
	reg [7:0] dirF;
	reg [7:0] dirG;
	reg [7:0] pueA;
	reg [7:0] pueC;
	reg [7:0] pueD;
	reg [7:0] pueF;

	wire [10:0] regIndex;
	wire [7:0] wrByte;
	wire writeTake;
	wire [55:0] latchFlat;
	reg latchWrite;
	reg [2:0] latchSlot;
	reg [7:0] latchData;
	reg [7:0] next_readByte;

	// byte address to word index; registers live in the low byte lane
	assign regIndex = address[12:2];
	assign wrByte = writedata[7:0];
	// a write lands at the edge where waitrequest is seen low
	assign writeTake = write & ~waitrequest & byteenable[0];

	// ----------------------------------------------------------------
	// data latch path
	// ----------------------------------------------------------------

	// steer a latch write to its slot, masking unimplemented bits
	// the bank has no reset input, so srst cannot disturb a latch by mistake
	always @* begin
		latchWrite = 1'b0;
		latchSlot = `SLOT_A;
		latchData = wrByte;
		if (writeTake) begin
			case (regIndex)
				`IDX_PORT_A_LATCH: begin
					latchWrite = 1'b1;
					latchSlot = `SLOT_A;
				end
				`IDX_PORT_B_LATCH: begin
					latchWrite = 1'b1;
					latchSlot = `SLOT_B;
				end
				`IDX_PORT_C_LATCH: begin
					latchWrite = 1'b1;
					latchSlot = `SLOT_C;
					latchData = wrByte & `MASK_PORT_C;
				end
				`IDX_PORT_D_LATCH: begin
					latchWrite = 1'b1;
					latchSlot = `SLOT_D;
				end
				`IDX_PORT_E_LATCH: begin
					latchWrite = 1'b1;
					latchSlot = `SLOT_E;
					latchData = wrByte & `MASK_PORT_E;
				end
				`IDX_PORT_F_LATCH: begin
					latchWrite = 1'b1;
					latchSlot = `SLOT_F;
				end
				`IDX_PORT_G_LATCH: begin
					latchWrite = 1'b1;
					latchSlot = `SLOT_G;
				end
				default: begin
					latchWrite = 1'b0;
				end
			endcase
		end
	end

	port_latch_bank latches (
		.clk(clk),
		.writeEnable(latchWrite),
		.writeSlot(latchSlot),
		.writeData(latchData),
		.latchFlat(latchFlat)
	);

	// ----------------------------------------------------------------
	// direction and pullup registers
	// ----------------------------------------------------------------

	// direction clears to inputs on reset; latches are not touched here
	always @(posedge clk) begin
		if (srst) begin
			dirA <= `DIRECTION_RESET;
			dirB <= `DIRECTION_RESET;
			dirC <= `DIRECTION_RESET;
			dirD <= `DIRECTION_RESET;
			dirE <= `DIRECTION_RESET;
			dirF <= `DIRECTION_RESET;
			dirG <= `DIRECTION_RESET;
			pueA <= `PULLUP_RESET;
			pueC <= `PULLUP_RESET;
			pueD <= `PULLUP_RESET;
			pueF <= `PULLUP_RESET;
		end else if (writeTake) begin
			case (regIndex)
				`IDX_PORT_A_DIRECTION: dirA <= wrByte;
				`IDX_PORT_B_DIRECTION: dirB <= wrByte;
				`IDX_PORT_C_DIRECTION: dirC <= wrByte & `MASK_PORT_C;
				`IDX_PORT_D_DIRECTION: dirD <= wrByte;
				`IDX_PORT_E_DIRECTION: dirE <= wrByte & `MASK_PORT_E;
				`IDX_PORT_F_DIRECTION: dirF <= wrByte;
				`IDX_PORT_G_DIRECTION: dirG <= wrByte;
				`IDX_PORT_A_PULLUP_ENABLE: pueA <= wrByte;
				`IDX_PORT_C_PULLUP_ENABLE: pueC <= wrByte & `MASK_PORT_C;
				`IDX_PORT_D_PULLUP_ENABLE: pueD <= wrByte;
				`IDX_PORT_F_PULLUP_ENABLE: pueF <= wrByte;
				default: begin
					dirA <= dirA;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read multiplexer
	// ----------------------------------------------------------------

	// unmapped indices read zero rather than stall the bus
	// pins are taken as synchronous, so the read path has no synchroniser
	always @* begin
		next_readByte = `READ_UNMAPPED;
		case (regIndex)
			`IDX_PORT_A_LATCH:
				next_readByte = portRead(latchFlat[7:0], dirA, pinIn[7:0], `MASK_FULL);
			`IDX_PORT_B_LATCH:
				next_readByte = portRead(latchFlat[15:8], dirB, pinIn[15:8], `MASK_FULL);
			`IDX_PORT_C_LATCH:
				next_readByte = portRead(latchFlat[23:16], dirC, pinIn[23:16], `MASK_PORT_C);
			`IDX_PORT_D_LATCH:
				next_readByte = portRead(latchFlat[31:24], dirD, pinIn[31:24], `MASK_FULL);
			`IDX_PORT_E_LATCH:
				next_readByte = portRead(latchFlat[39:32], dirE, pinIn[39:32], `MASK_PORT_E);
			`IDX_PORT_F_LATCH:
				next_readByte = portRead(latchFlat[47:40], dirF, pinIn[47:40], `MASK_FULL);
			`IDX_PORT_G_LATCH:
				next_readByte = portRead(latchFlat[55:48], dirG, pinIn[55:48], `MASK_FULL);
			`IDX_PORT_A_DIRECTION: next_readByte = dirA;
			`IDX_PORT_B_DIRECTION: next_readByte = dirB;
			`IDX_PORT_C_DIRECTION: next_readByte = dirC & `MASK_PORT_C;
			`IDX_PORT_D_DIRECTION: next_readByte = dirD;
			`IDX_PORT_E_DIRECTION: next_readByte = dirE & `MASK_PORT_E;
			`IDX_PORT_F_DIRECTION: next_readByte = dirF;
			`IDX_PORT_G_DIRECTION: next_readByte = dirG;
			`IDX_PORT_A_PULLUP_ENABLE: next_readByte = pueA;
			`IDX_PORT_C_PULLUP_ENABLE: next_readByte = pueC & `MASK_PORT_C;
			`IDX_PORT_D_PULLUP_ENABLE: next_readByte = pueD;
			`IDX_PORT_F_PULLUP_ENABLE: next_readByte = pueF;
			default: next_readByte = `READ_UNMAPPED;
		endcase
	end

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------

	// one wait state: request seen with waitrequest high, answer next edge.
	// the extra cycle lets read data come from a flop at the cost of latency
	// a master that keeps its request up past the answer is served again
	always @(posedge clk) begin
		if (srst) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else if ((read | write) & waitrequest) begin
			waitrequest <= 1'b0;
			if (read) begin
				readdata <= {24'h000000, next_readByte};
			end
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// pin control
	// ----------------------------------------------------------------
	reg [55:0] dirAll;
	reg [55:0] pueAll;
	reg [55:0] forceIn;
	reg [55:0] next_pinOe;
	reg [55:0] next_pinOut;
	reg [55:0] next_pullupOn;

	// peripheral ownership overrides direction; pullups exist on A, C, D, F
	// a pin handed to keyboard, converter or CAN receive is never driven, whatever its direction bit; the CAN transmit pin is always driven while canPinEnable is set
	always @* begin
		dirAll = {dirG, dirF, dirE & `MASK_PORT_E, dirD, dirC & `MASK_PORT_C, dirB, dirA};
		pueAll = {8'h00, pueF, 8'h00, pueD, pueC & `MASK_PORT_C, 8'h00, pueA};
		forceIn = 56'h00000000000000;
		// keyboard and converter take port A pins as inputs
		forceIn[7:0] = keyboardPinEnable |
			channelHit(converterChannelSelect, `CONV_BASE_A, converterActive);
		forceIn[15:8] = channelHit(converterChannelSelect, `CONV_BASE_B, converterActive);
		forceIn[55:48] = channelHit(converterChannelSelect, `CONV_BASE_G, converterActive);
		// CAN receive pin is input, transmit pin driven below
		forceIn[`PIN_CAN_RX] = canPinEnable;
		// direction one enables the driver, zero releases the pin
		next_pinOe = dirAll & ~forceIn;
		// latch reaches the pin only where driven
		next_pinOut = latchFlat & next_pinOe;
		if (canPinEnable) begin
			next_pinOe[`PIN_CAN_TX] = 1'b1;
			next_pinOut[`PIN_CAN_TX] = canTxData;
		end
		// pullup only while the bit is an undriven port input
		next_pullupOn = pueAll & ~next_pinOe & ~forceIn;
	end

	// register the pin side so every pin output is a flop
	always @(posedge clk) begin
		if (srst) begin
			pinOe <= 56'h00000000000000;
			pinOut <= 56'h00000000000000;
			pullupOn <= 56'h00000000000000;
		end else begin
			pinOe <= next_pinOe;
			pinOut <= next_pinOut;
			pullupOn <= next_pullupOn;
		end
	end

endmodule // parallel_io_ports

// >>> hdl/parallel_io_ports_defs.vh
`ifndef PARALLEL_IO_PORTS_DEFS_VH
`define PARALLEL_IO_PORTS_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PORT_A_LATCH 11'h000
`define IDX_PORT_B_LATCH 11'h001
`define IDX_PORT_C_LATCH 11'h002
`define IDX_PORT_D_LATCH 11'h003
`define IDX_PORT_A_DIRECTION 11'h004
`define IDX_PORT_B_DIRECTION 11'h005
`define IDX_PORT_C_DIRECTION 11'h006
`define IDX_PORT_D_DIRECTION 11'h007
`define IDX_PORT_E_LATCH 11'h008
`define IDX_PORT_E_DIRECTION 11'h00C
`define IDX_PORT_A_PULLUP_ENABLE 11'h00D
`define IDX_PORT_C_PULLUP_ENABLE 11'h00E
`define IDX_PORT_D_PULLUP_ENABLE 11'h00F
`define IDX_PORT_F_LATCH 11'h440
`define IDX_PORT_G_LATCH 11'h441
`define IDX_PORT_F_DIRECTION 11'h444
`define IDX_PORT_G_DIRECTION 11'h445
`define IDX_PORT_F_PULLUP_ENABLE 11'h446

// ----------------------------------------------------------------
// implemented bit masks and reset values
// ----------------------------------------------------------------
`define MASK_FULL 8'hFF
`define MASK_PORT_C 8'h7F
`define MASK_PORT_E 8'h3F
`define DIRECTION_RESET 8'h00
`define PULLUP_RESET 8'h00
`define READ_UNMAPPED 8'h00

// ----------------------------------------------------------------
// latch bank slots
// ----------------------------------------------------------------
`define SLOT_A 3'h0
`define SLOT_B 3'h1
`define SLOT_C 3'h2
`define SLOT_D 3'h3
`define SLOT_E 3'h4
`define SLOT_F 3'h5
`define SLOT_G 3'h6

// ----------------------------------------------------------------
// shared functions
// ----------------------------------------------------------------
`define CONV_BASE_B 5'h00
`define CONV_BASE_A 5'h08
`define CONV_BASE_G 5'h10
`define PIN_CAN_TX 16
`define PIN_CAN_RX 17

`endif

// >>> hdl/port_latch_bank.v
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port data latches, seven bytes, untouched by reset
// ----------------------------------------------------------------
module port_latch_bank (
	input wire clk,
	input wire writeEnable,
	input wire [2:0] writeSlot,
	input wire [7:0] writeData,
	output wire [55:0] latchFlat
);
	reg [7:0] mem [0:6];

	// no reset term: the latches keep their contents across reset
	always @(posedge clk) begin
		if (writeEnable) begin
			mem[writeSlot] <= writeData;
		end
	end

	// every slot is a flip-flop, so the pins see a registered value
	assign latchFlat = {mem[6], mem[5], mem[4], mem[3], mem[2], mem[1], mem[0]};
endmodule // port_latch_bank

// >>> verif/pin_board_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// board pins: driven level, else pullup, else board level
// ----------------------------------------------------------------
module pin_board_model (
	input wire [55:0] pinOut,
	input wire [55:0] pinOe,
	input wire [55:0] pullupOn,
	input wire [55:0] ext,
	output wire [55:0] pinIn
);
	// undriven pulled-up lines float high; the board level only shows elsewhere
	assign pinIn = (pinOe & pinOut) | (~pinOe & pullupOn) | (~pinOe & ~pullupOn & ext);
endmodule // pin_board_model

// >>> verif/parallel_io_ports_sva.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// bus and pin checks
// ----------------------------------------------------------------
module parallel_io_ports_sva (
	input wire clk,
	input wire srst,
	input wire read,
	input wire write,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire [55:0] pinOut,
	input wire [55:0] pinOe,
	input wire [55:0] pullupOn,
	input wire [7:0] keyboardPinEnable,
	input wire [4:0] converterChannelSelect,
	input wire converterActive,
	input wire canPinEnable,
	input wire canTxData
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// a request gets exactly one low cycle of waitrequest
	sequence taken; (read || write) && waitrequest; endsequence
	sequence answer; !waitrequest ##1 waitrequest; endsequence
	bus_answer_a: assert property (taken |=> answer)
		else $error("bus answer missing");
	upper_zero_a: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	reset_clear_a: assert property ($fell(srst) |-> pinOe == 56'h0 && pullupOn == 56'h0)
		else $error("pins not cleared by reset");
	pullup_off_a: assert property ((pinOe & pullupOn) == 56'h0)
		else $error("pullup on a driven pin");
	pullup_ports_a: assert property ((pullupOn & 56'hFF00FF0000FF00) == 56'h0)
		else $error("pullup on a port without pullups");
	drive_gate_a: assert property ((pinOut & ~pinOe) == 56'h0)
		else $error("output value on undriven pin");
	unused_bits_a: assert property (pinOe[39:38] == 2'h0 && !pinOe[23])
		else $error("unimplemented pin driven");
	keyboard_input_a: assert property ((pinOe[7:0] & $past(keyboardPinEnable)) == 8'h00)
		else $error("keyboard pin still driven");
	can_pins_a: assert property (canPinEnable |=> !pinOe[17] && pinOut[16] == $past(canTxData))
		else $error("can pins not handed over");
	converter_input_a: assert property (converterActive && converterChannelSelect[4:3] == 2'h1
		|=> !pinOe[$past(converterChannelSelect[2:0])])
		else $error("converter pin still driven");
endmodule // parallel_io_ports_sva

bind parallel_io_ports parallel_io_ports_sva u_sva (.clk(clk), .srst(srst), .read(read),
	.write(write), .readdata(readdata), .waitrequest(waitrequest), .pinOut(pinOut),
	.pinOe(pinOe), .pullupOn(pullupOn), .keyboardPinEnable(keyboardPinEnable),
	.converterChannelSelect(converterChannelSelect), .converterActive(converterActive),
	.canPinEnable(canPinEnable), .canTxData(canTxData));

// >>> verif/parallel_io_ports_test.sv
`timescale 1ns/1ns
`include "parallel_io_ports_defs.vh"
// ----------------------------------------------------------------
// register and pin scenarios
// ----------------------------------------------------------------
module parallel_io_ports_test;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [12:0] address = 13'h0000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [55:0] pinIn, pinOut, pinOe, pullupOn;
	logic [55:0] ext = 56'h3C96A50FC3695A;
	logic [7:0] keyboardPinEnable = 8'h00;
	logic [4:0] converterChannelSelect = 5'h00;
	logic converterActive = 1'b0;
	logic canPinEnable = 1'b0;
	logic canTxData = 1'b0;
	logic [7:0] rv;
	int failCount = 0;
	int checks = 0;
	// 20 MHz clock
	always #25 clk = ~clk;
	parallel_io_ports u_dut (.clk(clk), .srst(srst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.pullupOn(pullupOn), .keyboardPinEnable(keyboardPinEnable),
		.converterChannelSelect(converterChannelSelect), .converterActive(converterActive),
		.canPinEnable(canPinEnable), .canTxData(canTxData));
	pin_board_model u_board (.pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn),
		.ext(ext), .pinIn(pinIn));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			failCount++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is sampled low; one idle edge follows
	// no cycle limit here: only the watchdog ends a wait
	task automatic bus(input logic rd, input logic [10:0] i, input logic [7:0] d,
		input logic [3:0] be);
		address <= {i, 2'b00};
		read <= rd;
		write <= ~rd;
		writedata <= {24'h000000, d};
		byteenable <= be;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		chk(waitrequest, 1'b0);
		rv = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [10:0] i, input logic [7:0] d);
		bus(1'b0, i, d, 4'h1);
	endtask
	task automatic rdc(input logic [10:0] i, input logic [7:0] e);
		bus(1'b1, i, 8'h00, 4'h0);
		chk(rv, e);
	endtask
	// pins lag the register by one clock
	task settle;
		repeat (2) @(posedge clk);
	endtask
	task t_reset;
		logic [10:0] regs [8] = '{11'h004, 11'h005, 11'h006, 11'h007, 11'h00C, 11'h00D,
			11'h00E, 11'h00F};
		foreach (regs[k]) rdc(regs[k], 8'h00);
		chk(pinOe, 56'h0);
		$display("reset test done");
	endtask
	task t_direction;
		wr(`IDX_PORT_A_LATCH, 8'hA5);
		wr(`IDX_PORT_A_DIRECTION, 8'h0F);
		settle;
		chk(pinOe[7:0], 8'h0F);
		chk(pinOut[7:0], 8'h05);
		rdc(`IDX_PORT_A_LATCH, 8'h05 | (ext[7:0] & 8'hF0));
		wr(`IDX_PORT_A_DIRECTION, 8'hF0);
		settle;
		chk(pinOut[7:0], 8'hA0);
		$display("direction test done");
	endtask
	task t_pullups;
		wr(`IDX_PORT_A_PULLUP_ENABLE, 8'hFF);
		settle;
		chk(pullupOn[7:0], 8'h0F);
		rdc(`IDX_PORT_A_LATCH, 8'hAF);
		wr(`IDX_PORT_A_DIRECTION, 8'h00);
		wr(`IDX_PORT_D_PULLUP_ENABLE, 8'hFF);
		settle;
		chk(pullupOn[7:0], 8'hFF);
		chk(pullupOn[31:24], 8'hFF);
		wr(`IDX_PORT_C_PULLUP_ENABLE, 8'hFF);
		rdc(`IDX_PORT_C_PULLUP_ENABLE, 8'h7F);
		$display("pullup test done");
	endtask
	task t_masks;
		wr(`IDX_PORT_C_DIRECTION, 8'hFF);
		rdc(`IDX_PORT_C_DIRECTION, 8'h7F);
		wr(`IDX_PORT_E_DIRECTION, 8'hFF);
		wr(`IDX_PORT_E_LATCH, 8'hFF);
		rdc(`IDX_PORT_E_DIRECTION, 8'h3F);
		rdc(`IDX_PORT_E_LATCH, 8'h3F);
		bus(1'b0, `IDX_PORT_B_DIRECTION, 8'hFF, 4'h0);
		rdc(`IDX_PORT_B_DIRECTION, 8'h00);
		wr(11'h010, 8'hFF);
		rdc(11'h010, 8'h00);
		$display("mask test done");
	endtask
	task t_sharing;
		wr(`IDX_PORT_A_DIRECTION, 8'hFF);
		wr(`IDX_PORT_G_LATCH, 8'h5A);
		wr(`IDX_PORT_G_DIRECTION, 8'hFF);
		keyboardPinEnable <= 8'h01;
		converterActive <= 1'b1;
		converterChannelSelect <= 5'h09;
		canPinEnable <= 1'b1;
		canTxData <= 1'b1;
		settle;
		chk(pinOe[7:0], 8'hFC);
		chk({pinOe[17], pinOut[16]}, 2'h1);
		chk(pullupOn[7:0], 8'h00);
		chk(pinOe[55:48], 8'hFF);
		canTxData <= 1'b0;
		keyboardPinEnable <= 8'h00;
		converterActive <= 1'b0;
		settle;
		chk({pinOe[7:0], pinOut[16]}, 9'h1FE);
		canPinEnable <= 1'b0;
		converterActive <= 1'b1;
		converterChannelSelect <= 5'h12;
		settle;
		chk(pinOe[55:48], 8'hFB);
		chk(pinOe[17], 1'b1);
		converterActive <= 1'b0;
		$display("sharing test done");
	endtask
	task t_keep;
		wr(`IDX_PORT_F_LATCH, 8'h3C);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		rdc(`IDX_PORT_A_DIRECTION, 8'h00);
		wr(`IDX_PORT_F_DIRECTION, 8'hFF);
		settle;
		chk(pinOut[47:40], 8'h3C);
		rdc(`IDX_PORT_F_LATCH, 8'h3C);
		$display("latch keep test done");
	endtask
	task report_and_stop;
		$display("checks=%0d mismatches=%0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset;
		t_direction;
		t_pullups;
		t_masks;
		t_sharing;
		t_keep;
		report_and_stop;
	end
	// watchdog, far above the under two hundred cycles the tests need
	initial begin
		repeat (3000) @(posedge clk);
		failCount++;
		report_and_stop;
	end
endmodule // parallel_io_ports_test
